// ===== rtl/bcu_cfg.svh
// Constant definitions for the branch condition unit.
`ifndef BCU_CFG_SVH
`define BCU_CFG_SVH

// Register byte offsets on the APB bus.
`define BCU_OFS_CMD      8'h00
`define BCU_OFS_OPERAND  8'h04
`define BCU_OFS_FLAGS    8'h08
`define BCU_OFS_PC       8'h0C
`define BCU_OFS_STATUS   8'h10

// Command register fields.
`define BCU_CMD_OP_LSB   0
`define BCU_CMD_OP_MSB   2
`define BCU_CMD_CC_LSB   4
`define BCU_CMD_CC_MSB   7

// Flag register bit positions.
`define BCU_FLAG_C       0
`define BCU_FLAG_V       1
`define BCU_FLAG_Z       2
`define BCU_FLAG_N       3

// Status register bit positions.
`define BCU_ST_DEPTH_LSB 0
`define BCU_ST_DEPTH_MSB 3
`define BCU_ST_TAKEN     8
`define BCU_ST_ERR       9

// Sizes and reset values.
`define BCU_ADDR_W       16
`define BCU_STACK_DEPTH  8
`define BCU_INSN_LEN     16'h0002
`define BCU_PC_RESET     16'h0000

// Condition field codes.
`define BCU_CC_ALWAYS    4'h0
`define BCU_CC_NEVER     4'h1
`define BCU_CC_HI        4'h2
`define BCU_CC_LS        4'h3
`define BCU_CC_CCLR      4'h4
`define BCU_CC_CSET      4'h5
`define BCU_CC_NE        4'h6
`define BCU_CC_EQ        4'h7
`define BCU_CC_VCLR      4'h8
`define BCU_CC_VSET      4'h9
`define BCU_CC_PL        4'hA
`define BCU_CC_MI        4'hB
`define BCU_CC_GE        4'hC
`define BCU_CC_LT        4'hD
`define BCU_CC_GT        4'hE
`define BCU_CC_LE        4'hF

`endif

// ===== rtl/bcu_cond_eval.sv
// Condition field evaluator for the conditional branch.
`timescale 1ns/10ps
`default_nettype none
`include "bcu_cfg.svh"

module bcu_cond_eval (
    // Condition code and flags.
    input  wire logic [3:0] condition_field,
    input  wire logic [3:0] flags,
    // Result.
    output logic            take
);

    logic c;
    logic v;
    logic z;
    logic n;
    logic nv;

    assign c  = flags[`BCU_FLAG_C];
    assign v  = flags[`BCU_FLAG_V];
    assign z  = flags[`BCU_FLAG_Z];
    assign n  = flags[`BCU_FLAG_N];
    assign nv = n ^ v;

    // One entry per code; odd codes are the inverse test of the even code below them.
    always_comb begin
        case (condition_field)
            `BCU_CC_ALWAYS: take = 1'b1;
            `BCU_CC_NEVER:  take = 1'b0;
            `BCU_CC_HI:     take = ~(c | z);
            `BCU_CC_LS:     take = c | z;
            `BCU_CC_CCLR:   take = ~c;
            `BCU_CC_CSET:   take = c;
            `BCU_CC_NE:     take = ~z;
            `BCU_CC_EQ:     take = z;
            `BCU_CC_VCLR:   take = ~v;
            `BCU_CC_VSET:   take = v;
            `BCU_CC_PL:     take = ~n;
            `BCU_CC_MI:     take = n;
            `BCU_CC_GE:     take = ~nv;
            `BCU_CC_LT:     take = nv;
            `BCU_CC_GT:     take = ~(z | nv);
            `BCU_CC_LE:     take = z | nv;
            default:        take = 1'b0;
        endcase
    end

endmodule : bcu_cond_eval
`default_nettype wire

// ===== rtl/bcu_pkg.sv
// Types shared by the branch condition unit.
package bcu_pkg;

    // Branch operation selected by the command register.
    typedef enum logic [2:0] {
        BCU_OP_NONE          = 3'h0,
        BCU_OP_BRANCH_COND   = 3'h1,
        BCU_OP_JUMP_ABSOLUTE = 3'h2,
        BCU_OP_CALL_ABSOLUTE = 3'h3,
        BCU_OP_CALL_RELATIVE = 3'h4,
        BCU_OP_RETURN        = 3'h5
    } bcu_op_e;

    typedef logic [15:0] bcu_addr_t;

endpackage : bcu_pkg

// ===== rtl/bcu_top.sv
// Branch condition unit: APB registers, branch decode, program counter and return stack.
`timescale 1ns/10ps
`default_nettype none
`include "bcu_cfg.svh"

// Functional notes
// - Branch on selected condition; 0000 always, 0001 never.
// - 0010/0011 test C or Z; 0100/0101 carry.
// - 0110/0111 zero, 1000/1001 overflow, 1010/1011 negative.
// - 1100/1101 N xor V; 1110/1111 add Z.
// - Absolute jump ignores flags entirely.
// - Absolute call goes to given address.
// - Relative call adds displacement to current address.
// - Return resumes after the calling point.
module bcu_top (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Program counter update side.
    output logic      [15:0] pc_value,
    output logic             pc_load,
    output logic             branch_taken
);

    localparam int DEPTH = `BCU_STACK_DEPTH;

    // Address of the instruction after the current one; wraps at the top of the 16-bit space.
    function automatic bcu_pkg::bcu_addr_t next_seq(input bcu_pkg::bcu_addr_t pc);
        return 16'(pc + `BCU_INSN_LEN);
    endfunction : next_seq

    logic              acc_wr;
    logic              acc_rd;
    logic              acc_setup;
    logic              addr_ok;
    logic              cond_take;
    bcu_pkg::bcu_op_e  cmd_op;
    logic [3:0]        cmd_cc;

    bcu_pkg::bcu_addr_t operand_q;
    bcu_pkg::bcu_addr_t operand_d;
    logic [3:0]         flags_q;
    logic [3:0]         flags_d;
    bcu_pkg::bcu_addr_t pc_q;
    bcu_pkg::bcu_addr_t pc_d;
    logic               load_q;
    logic               load_d;
    logic               taken_q;
    logic               taken_d;
    logic               err_q;
    logic               err_d;
    logic [3:0]         depth_q;
    logic [3:0]         depth_d;
    bcu_pkg::bcu_addr_t stack_q [DEPTH];
    bcu_pkg::bcu_addr_t stack_d [DEPTH];
    logic [31:0]        rdata_q;
    logic [31:0]        rdata_d;
    logic               slverr_q;
    logic               slverr_d;

    // Every access completes in its first access cycle, so no wait states.
    // Read data and the error answer are captured at the setup edge, so both come
    // straight from flip-flops and still stand for the whole access phase.
    assign pready    = 1'b1;
    assign pslverr   = slverr_q;
    assign prdata    = rdata_q;
    assign acc_setup = psel & ~penable;
    assign acc_wr    = psel & penable & pwrite;
    assign acc_rd    = acc_setup & ~pwrite;
    assign cmd_op  = bcu_pkg::bcu_op_e'(pwdata[`BCU_CMD_OP_MSB:`BCU_CMD_OP_LSB]);
    assign cmd_cc  = pwdata[`BCU_CMD_CC_MSB:`BCU_CMD_CC_LSB];

    assign pc_value     = pc_q;
    assign pc_load      = load_q;
    assign branch_taken = taken_q;

    // Decode of the five mapped word offsets.
    always_comb begin
        case (paddr)
            `BCU_OFS_CMD, `BCU_OFS_OPERAND, `BCU_OFS_FLAGS, `BCU_OFS_PC, `BCU_OFS_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // The test uses the flags held before the command write, never the ones it carries.
    bcu_cond_eval u_cond (
        .condition_field (cmd_cc),
        .flags           (flags_q),
        .take            (cond_take)
    );

    // Read data and error answer for the coming access phase. Outside it both fall
    // back to zero, because the setup term is low at the access edge.
    // Only this bus writes the registers, so nothing can change between the two edges.
    always_comb begin
        rdata_d  = 32'h0000_0000;
        slverr_d = acc_setup & ~addr_ok;
        if (acc_rd) begin
            case (paddr)
                `BCU_OFS_OPERAND: rdata_d = {16'h0000, operand_q};
                `BCU_OFS_FLAGS:   rdata_d = {28'h000_0000, flags_q};
                `BCU_OFS_PC:      rdata_d = {16'h0000, pc_q};
                `BCU_OFS_STATUS: begin
                    rdata_d[`BCU_ST_DEPTH_MSB:`BCU_ST_DEPTH_LSB] = depth_q;
                    rdata_d[`BCU_ST_TAKEN]                        = taken_q;
                    rdata_d[`BCU_ST_ERR]                          = err_q;
                end
                default:          rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Next-state logic: register writes, then the command executes in the same access.
    always_comb begin
        operand_d = operand_q;
        flags_d   = flags_q;
        pc_d      = pc_q;
        load_d    = 1'b0;
        taken_d   = taken_q;
        err_d     = err_q;
        depth_d   = depth_q;
        for (int i = 0; i < DEPTH; i++) begin
            stack_d[i] = stack_q[i];
        end
        if (acc_wr) begin
            case (paddr)
                `BCU_OFS_OPERAND: operand_d = pwdata[15:0];
                `BCU_OFS_FLAGS:   flags_d   = pwdata[3:0];
                `BCU_OFS_PC:      pc_d      = pwdata[15:0];
                `BCU_OFS_STATUS:  err_d     = err_q & ~pwdata[`BCU_ST_ERR];
                `BCU_OFS_CMD: begin
                    // Only the five defined operations load; the rest are ignored.
                    load_d  = 1'b1;
                    taken_d = 1'b1;
                    case (cmd_op)
                        // conditional branch, falls through when false
                        bcu_pkg::BCU_OP_BRANCH_COND: begin
                            taken_d = cond_take;
                            // The offset is added to the branch's own address, not the next one.
                            pc_d    = cond_take ? 16'(pc_q + operand_q) : next_seq(pc_q);
                        end
                        bcu_pkg::BCU_OP_JUMP_ABSOLUTE: pc_d = operand_q;
                        bcu_pkg::BCU_OP_CALL_ABSOLUTE, bcu_pkg::BCU_OP_CALL_RELATIVE: begin
                            pc_d = (cmd_op == bcu_pkg::BCU_OP_CALL_ABSOLUTE) ? operand_q
                                                                            : 16'(pc_q + operand_q);
                            if (depth_q < 4'(DEPTH)) begin
                                stack_d[depth_q[2:0]] = next_seq(pc_q);
                                depth_d               = 4'(depth_q + 4'h1);
                            end else begin
                                // A full stack still jumps; the lost return address is flagged.
                                err_d = 1'b1;
                            end
                        end
                        bcu_pkg::BCU_OP_RETURN: begin
                            if (depth_q != 4'h0) begin
                                pc_d    = stack_q[3'(depth_q - 4'h1)];
                                depth_d = 4'(depth_q - 4'h1);
                            end else begin
                                // An empty stack cannot return; step on and flag it.
                                pc_d    = next_seq(pc_q);
                                taken_d = 1'b0;
                                err_d   = 1'b1;
                            end
                        end
                        // No operation and unused codes leave the counter and the result as they are.
                        default: begin
                            load_d  = 1'b0;
                            taken_d = taken_q;
                        end
                    endcase
                end
                default: err_d = err_q;
            endcase
        end
    end

    // State registers; the stack entries themselves need no reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand_q <= 16'h0000;
            flags_q   <= 4'h0;
            pc_q      <= `BCU_PC_RESET;
            load_q    <= 1'b0;
            taken_q   <= 1'b0;
            err_q     <= 1'b0;
            depth_q   <= 4'h0;
            rdata_q   <= 32'h0000_0000;
            slverr_q  <= 1'b0;
        end else begin
            operand_q <= operand_d;
            flags_q   <= flags_d;
            pc_q      <= pc_d;
            load_q    <= load_d;
            taken_q   <= taken_d;
            err_q     <= err_d;
            depth_q   <= depth_d;
            rdata_q   <= rdata_d;
            slverr_q  <= slverr_d;
        end
    end

    // Return stack storage; entries above the depth are never read, so a reset is not needed.
    always_ff @(posedge pclk) begin
        for (int i = 0; i < DEPTH; i++) begin
            stack_q[i] <= stack_d[i];
        end
    end

endmodule : bcu_top
`default_nettype wire

// ===== verif/bcu_fetch_model.sv
// Fetch side model that follows program counter loads.
`timescale 1ns/10ps
`default_nettype none
module bcu_fetch_model (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Load from the unit.
    input  wire logic        pc_load,
    input  wire logic [15:0] pc_value,
    // Fetch pointer.
    output logic      [15:0] fetch_pc
);
    // Fetch redirects only on a load pulse, never on a plain counter write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_pc <= 16'h0000;
        end else if (pc_load) begin
            fetch_pc <= pc_value;
        end
    end
endmodule : bcu_fetch_model
`default_nettype wire

// ===== verif/bcu_top_asserts.sv
// Port checker for the branch condition unit.
`timescale 1ns/10ps
`default_nettype none
module bcu_top_chk (
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // Bus side.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Program counter side.
    input wire logic [15:0] pc_value,
    input wire logic        pc_load,
    input wire logic        branch_taken
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A command write naming one of the five operations.
    wire acc = psel && penable;
    wire go  = acc && pwrite && paddr == 8'h00 && pwdata[2:0] inside {[3'h1:3'h5]};
    load_follows_a: assert property (go |=> pc_load) else $error("no load after command");
    no_stray_a: assert property (!go |=> !pc_load) else $error("load without command");
    never_seq_a: assert property (go && pwdata[7:0] == 8'h11 |=>
        !branch_taken && pc_value == $past(pc_value) + 16'h0002) else $error("never branch moved");
    always_br_a: assert property (go && pwdata[7:0] == 8'h01 |=> branch_taken) else $error("always not taken");
    jump_taken_a: assert property (go && pwdata[2:0] == 3'h2 |=> branch_taken) else $error("jump not taken");
    call_taken_a: assert property (go && pwdata[2:0] == 3'h3 |=> branch_taken) else $error("call not taken");
    bus_quiet_a: assert property (!acc |-> !pslverr && prdata == 32'h0) else $error("bus not quiet");
    pc_steady_a: assert property (!pc_load && !$past(acc && pwrite && paddr == 8'h0C) |->
        $stable(pc_value)) else $error("counter moved alone");
    cover property (go && pwdata[2:0] == 3'h4);
    cover property (go && pwdata[2:0] == 3'h5);
    cover property (acc && pslverr);
    cover property (acc && pready && !pwrite);
endmodule : bcu_top_chk
bind bcu_top bcu_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .paddr,
    .pwdata, .prdata, .pc_value, .pc_load, .branch_taken);
`default_nettype wire

// ===== verif/bcu_top_tb.sv
// Self-checking bench for the branch condition unit.
`timescale 1ns/10ps
`default_nettype none
module bcu_top_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic        pready, pslverr, pc_load, branch_taken;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [15:0] pc_value, fetch_pc, m_pc = 0, m_opnd = 0, last = 0;
    logic [15:0] stk[$];
    logic [16:0] exp_q[$], e;
    logic [3:0]  m_fl = 0;
    int          n_fail = 0, samples_checked = 0, n;
    bcu_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pc_value, .pc_load, .branch_taken);
    bcu_fetch_model u_fetch (.pclk, .presetn, .pc_load, .pc_value, .fetch_pc);
    // Free-running bus clock.
    always #12.5 pclk = ~pclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_fail++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk
    // One bus transfer; the request is held until ready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    function automatic logic cond(input logic [3:0] cc, input logic [3:0] f);
        logic r;
        case (cc[3:1])
            3'h0: r = 1'b1;
            3'h1: r = !(f[0] | f[2]);
            3'h2: r = !f[0];
            3'h3: r = !f[2];
            3'h4: r = !f[1];
            3'h5: r = !f[3];
            3'h6: r = !(f[3] ^ f[1]);
            default: r = !(f[2] | (f[3] ^ f[1]));
        endcase
        return r ^ cc[0];
    endfunction : cond
    // Notes the expected outcome, then issues the command.
    task automatic op_run(input logic [2:0] op, input logic [3:0] cc);
        logic t;
        logic [15:0] x;
        t = 1'b1;
        x = m_opnd;
        case (op)
            3'h1: begin t = cond(cc, m_fl); x = t ? m_pc + m_opnd : m_pc + 16'h0002; end
            3'h3, 3'h4: begin if (op == 3'h4) x = m_pc + m_opnd; if (stk.size() < 8) stk.push_back(m_pc + 16'h0002); end
            3'h5: begin t = stk.size() > 0; x = t ? stk.pop_back() : m_pc + 16'h0002; end
            default: ;
        endcase
        exp_q.push_back({t, x});
        m_pc = x;
        apb(1'b1, 8'h00, {24'h0, cc, 1'b0, op});
    endtask : op_run
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    // Takes the oldest note whenever a load appears; otherwise checks the fetch side.
    always @(posedge pclk) begin
        if (presetn && pc_load) begin
            e = exp_q.pop_front();
            chk({15'h0, branch_taken, pc_value}, {15'h0, e});
            last = e[15:0];
        end else if (presetn) chk({16'h0, fetch_pc}, {16'h0, last});
    end
    // Guards against a hang well past the expected run length.
    initial begin
        #500000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        n = $urandom(59);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({15'h0, branch_taken, pc_value}, 32'h0);
        for (int i = 0; i < 256; i++) begin
            m_fl = i[7:4];
            m_opnd = 16'($urandom) & 16'hFFFE;
            apb(1'b1, 8'h08, {28'h0, m_fl});
            apb(1'b1, 8'h04, {16'h0, m_opnd});
            op_run(3'h1, i[3:0]);
        end
        $display("test conditions done");
        op_run(3'h2, 4'h1);
        apb(1'b1, 8'h00, 32'h0000_0006);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0000_0100);
        m_pc = 16'h1234;
        apb(1'b1, 8'h0C, {16'h0, m_pc});
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, {16'h0, m_pc});
        $display("test jump done");
        for (int j = 0; j < 9; j++) begin
            m_opnd = 16'($urandom) & 16'hFFFE;
            apb(1'b1, 8'h04, {16'h0, m_opnd});
            op_run(j[0] ? 3'h3 : 3'h4, 4'h0);
        end
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0000_0308);
        for (int j = 0; j < 9; j++) op_run(3'h5, 4'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0000_0200);
        $display("test calls done");
        apb(1'b1, 8'h10, 32'h0000_0200);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        $display("test bus done");
        repeat (3) @(posedge pclk);
        chk(exp_q.size(), 32'h0);
        report_and_stop();
    end
endmodule : bcu_top_tb
`default_nettype wire
